// File: ccac_pkg.sv
package ccac_pkg;
  // Wishbone word offsets (byte address = index * 2)
  localparam logic [3:0] ADDR_CFGCAL = 4'h0;
  localparam logic [3:0] ADDR_ALCFG = 4'h1;
  localparam logic [3:0] ADDR_WEEKDAY_HOUR_VALUE = 4'h2;
  localparam logic [3:0] ADDR_MINUTE_SECOND_VALUE = 4'h3;
  localparam logic [3:0] ADDR_ALWIN_LO = 4'h4;
  localparam logic [3:0] ADDR_ALWIN_HI = 4'h5;
  localparam logic [3:0] ADDR_MTHDY = 4'h6;
  // Config register bit positions
  localparam int CFG_EN_BIT = 15;
  localparam int CFG_WREN_BIT = 13;
  localparam int CFG_SYNC_BIT = 12;
  localparam int CFG_HALF_BIT = 11;
  localparam int ALC_EN_BIT = 15;
  localparam int ALC_ENDLESS_REPEAT_BIT = 14;
  // Implemented-bit masks
  localparam logic [15:0] WEEKDAY_HOUR_VALUE_MASK = 16'h073f;
  localparam logic [15:0] MINUTE_SECOND_VALUE_MASK = 16'h7f7f;
  localparam logic [15:0] MTHDY_MASK = 16'h1f3f;
  // Window pointer codes
  localparam logic [1:0] PTR_MINUTE_SECOND_VALUE = 2'h0;
  localparam logic [1:0] PTR_WDHR = 2'h1;
  localparam logic [1:0] PTR_MTHDY = 2'h2;
  // Interval mask codes
  localparam logic [3:0] AM_HALF = 4'h0;
  localparam logic [3:0] AM_SEC = 4'h1;
  localparam logic [3:0] AM_10S = 4'h2;
  localparam logic [3:0] AM_MIN = 4'h3;
  localparam logic [3:0] AM_10M = 4'h4;
  localparam logic [3:0] AM_HOUR = 4'h5;
  localparam logic [3:0] AM_DAY = 4'h6;
  localparam logic [3:0] AM_WEEK = 4'h7;
  localparam logic [3:0] AM_MONTH = 4'h8;
  localparam logic [3:0] AM_YEAR = 4'h9;
  // Time base
  localparam int CLK_HZ = 100000000;
  localparam int TB_HZ = 32768;
  localparam int TB_DIV = CLK_HZ / TB_HZ;
  localparam int HALF_TICKS = 16384;
  localparam int CAL_SCALE = 4;
  localparam logic [7:0] RPT_MAX = 8'hff;

  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic [1:0] sel;
    logic [15:0] dat;
  } ccac_req_t;
endpackage : ccac_pkg

// File: ccac_sva.sv
module ccac_sva #(
  parameter int TB_DIV = 2,
  parameter int HALF_TICKS = 4
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [15:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_alarm_irq,
  input wire logic o_alarm_pulse
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic rd;
  assign rd = o_wb_ack && !i_wb_we;

  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_ack_prompt: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_wkdy_bits: assert property (
    rd && i_wb_adr == ccac_pkg::ADDR_WEEKDAY_HOUR_VALUE |->
    (o_wb_dat & ~ccac_pkg::WEEKDAY_HOUR_VALUE_MASK) == 16'h0000 &&
    o_wb_dat[10:8] <= 3'h6 && o_wb_dat[5:4] <= 2'h2)
    else $error("weekday/hour read out of form");
  a_minute_second_value_bits: assert property (
    rd && i_wb_adr == ccac_pkg::ADDR_MINUTE_SECOND_VALUE |->
    (o_wb_dat & ~ccac_pkg::MINUTE_SECOND_VALUE_MASK) == 16'h0000 &&
    o_wb_dat[14:12] <= 3'h5 && o_wb_dat[6:4] <= 3'h5)
    else $error("minute/second read out of form");
  a_mthdy_bits: assert property (
    rd && i_wb_adr == ccac_pkg::ADDR_MTHDY |->
    (o_wb_dat & ~ccac_pkg::MTHDY_MASK) == 16'h0000)
    else $error("month/day unimplemented bits set");
  a_unmapped_zero: assert property (
    rd && i_wb_adr > ccac_pkg::ADDR_MTHDY |-> o_wb_dat == 16'h0000)
    else $error("unmapped read not zero");
  a_irq_single: assert property (o_alarm_irq |=> !o_alarm_irq)
    else $error("irq longer than one cycle");
  a_pulse_irq: assert property (
    $changed(o_alarm_pulse) == o_alarm_irq)
    else $error("pulse toggle not paired with alarm");
  a_reset_quiet: assert property ($past(i_reset) |->
    !o_wb_ack && !o_alarm_irq && !o_alarm_pulse)
    else $error("outputs active after reset");

  c_irq: cover property (o_alarm_irq);
  c_pulse: cover property ($rose(o_alarm_pulse));
  c_read_minute_second_value: cover property (rd && i_wb_adr == ccac_pkg::ADDR_MINUTE_SECOND_VALUE);
endmodule : ccac_sva

// File: ccac_top.sv
// Behaviour
// - weekday three bits, 10:8, values 0-6
// - hour tens 5:4, ones 3:0
// - minute tens 14:12, ones 11:8
// - second tens 6:4, ones 3:0
// - unimplemented bits read zero, ignore writes
// - locked registers written only when unlocked
// - per-minute trim of four times calibration
// - final alarm clears alarm enable
// - interval mask selects matching digits
// - count zero, no endless_repeat: one alarm
// - count FFh gives 255 repeats
// - decrement after alarm, last disables
// - endless repeat wraps count to FFh
// - interrupt request on every alarm
// - alarm pulse toggles on every alarm
// - window pointer selects, decrements to 00
// - half-second flag cleared by seconds write
module ccac_top #(
  parameter int TB_DIV = ccac_pkg::TB_DIV,
  parameter int HALF_TICKS = ccac_pkg::HALF_TICKS
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [1:0] i_wb_sel,
  input wire logic [15:0] i_wb_dat,
  output logic [15:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_alarm_irq,
  output logic o_alarm_pulse
);
  ccac_pkg::ccac_req_t req;
  logic [15:0] cfg_reg;
  logic [15:0] alcfg_reg;
  logic [15:0] weekday_hour_value_reg;
  logic [15:0] minute_second_value_reg;
  logic [15:0] mthdy_reg;
  logic [15:0] al_mthdy_reg;
  logic [15:0] al_wdhr_reg;
  logic [15:0] al_minute_second_value_reg;
  logic [15:0] rd_next;
  logic [15:0] wmask;
  logic [15:0] div_reg;
  logic [15:0] tick_reg;
  logic [15:0] term_reg;
  logic [15:0] term_next;
  logic [5:0] sec_cnt_reg;
  logic half_reg;
  logic tb_tick;
  logic half_tick;
  logic sec_tick;
  logic wr;
  logic rd;
  logic unlocked;
  logic alarm_hit;
  logic match;
  logic [1:0] ptr;
  logic win_hi_access;
  logic [15:0] win_rd;

  assign req = '{adr: i_wb_adr, we: i_wb_we, sel: i_wb_sel, dat: i_wb_dat};
  assign wr = i_wb_cyc && i_wb_stb && req.we && !o_wb_ack;
  assign rd = i_wb_cyc && i_wb_stb && !req.we && !o_wb_ack;
  assign wmask = {{8{req.sel[1]}}, {8{req.sel[0]}}};
  assign unlocked = cfg_reg[ccac_pkg::CFG_WREN_BIT];
  assign ptr = alcfg_reg[9:8];
  assign win_hi_access = (wr || rd) && req.adr == ccac_pkg::ADDR_ALWIN_HI;

  // One-cycle answer to every access; unmapped reads return zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
    end else if (i_ce) begin
      o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
    end
  end

  // Time base: 32.768 kHz ticks derived from the system clock
  assign tb_tick = (div_reg == 16'(TB_DIV - 1));
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      div_reg <= 16'h0000;
    end else if (i_ce) begin
      div_reg <= tb_tick ? 16'h0000 : div_reg + 16'h0001;
    end
  end

  // Positive calibration adds pulses, so the half-second after the
  // minute rollover ends early; keep the depth above 508 base ticks
  // per-minute trim
  always_comb begin
    term_next = 16'(HALF_TICKS - 1);
    if (sec_tick && minute_second_value_reg[6:0] == 7'h59) begin
      term_next = 16'(HALF_TICKS - 1
        - ccac_pkg::CAL_SCALE * int'(signed'(cfg_reg[7:0])));
    end
  end
  assign half_tick = tb_tick && tick_reg == term_reg;
  assign sec_tick = half_tick && half_reg;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tick_reg <= 16'h0000;
    end else if (i_ce && cfg_reg[ccac_pkg::CFG_EN_BIT] && tb_tick) begin
      if (half_tick) begin
        tick_reg <= 16'h0000;
      end else begin
        tick_reg <= tick_reg + 16'h0001;
      end
    end
  end

  // Terminal count of the running half-second, reloaded at its end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      term_reg <= 16'(HALF_TICKS - 1);
    end else if (i_ce && cfg_reg[ccac_pkg::CFG_EN_BIT] && half_tick) begin
      term_reg <= term_next;
    end
  end

  // A toggle to one wins over a same-cycle clearing write
  // half flag cleared by write
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      half_reg <= 1'b0;
    end else if (i_ce) begin
      if (cfg_reg[ccac_pkg::CFG_EN_BIT] && half_tick) begin
        half_reg <= ~half_reg;
      end else if (wr && req.adr == ccac_pkg::ADDR_MINUTE_SECOND_VALUE && req.sel[0]) begin
        half_reg <= 1'b0;
      end
    end
  end

  // Sync warns of rollover ripple in the last ticks before a second
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sec_cnt_reg <= 6'h00;
    end else if (i_ce) begin
      sec_cnt_reg <= (half_reg && tick_reg > 16'(HALF_TICKS - 32))
        ? 6'h01 : 6'h00;
    end
  end

  // Config/calibration register; write enable guards the run bit
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_reg <= 16'h0000;
    end else if (i_ce && wr && req.adr == ccac_pkg::ADDR_CFGCAL) begin
      if (req.sel[0]) begin
        cfg_reg[7:0] <= req.dat[7:0];
      end
      if (req.sel[1]) begin
        cfg_reg[ccac_pkg::CFG_WREN_BIT] <= req.dat[ccac_pkg::CFG_WREN_BIT];
        if (unlocked) begin
          cfg_reg[ccac_pkg::CFG_EN_BIT] <= req.dat[ccac_pkg::CFG_EN_BIT];
        end
      end
    end
  end

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_inc

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      minute_second_value_reg <= 16'h0000;
      weekday_hour_value_reg <= 16'h0000;
      mthdy_reg <= 16'h0101;
    end else if (i_ce) begin
      if (wr && unlocked && req.adr == ccac_pkg::ADDR_WEEKDAY_HOUR_VALUE) begin
        weekday_hour_value_reg <= (weekday_hour_value_reg & ~wmask)
          | (req.dat & wmask & ccac_pkg::WEEKDAY_HOUR_VALUE_MASK);
      end else if (wr && unlocked && req.adr == ccac_pkg::ADDR_MTHDY) begin
        mthdy_reg <= (mthdy_reg & ~wmask)
          | (req.dat & wmask & ccac_pkg::MTHDY_MASK);
      end else if (wr && req.adr == ccac_pkg::ADDR_MINUTE_SECOND_VALUE) begin
        minute_second_value_reg <= (minute_second_value_reg & ~wmask)
          | (req.dat & wmask & ccac_pkg::MINUTE_SECOND_VALUE_MASK);
      end else if (cfg_reg[ccac_pkg::CFG_EN_BIT] && sec_tick) begin
        if (minute_second_value_reg[6:0] != 7'h59) begin
          minute_second_value_reg[7:0] <= bcd_inc(minute_second_value_reg[7:0]);
        end else begin
          minute_second_value_reg[7:0] <= 8'h00;
          if (minute_second_value_reg[14:8] != 7'h59) begin
            minute_second_value_reg[15:8] <= bcd_inc(minute_second_value_reg[15:8]);
          end else begin
            minute_second_value_reg[15:8] <= 8'h00;
            if (weekday_hour_value_reg[5:0] != 6'h23) begin
              weekday_hour_value_reg[7:0] <= bcd_inc(weekday_hour_value_reg[7:0]);
            end else begin
              weekday_hour_value_reg[7:0] <= 8'h00;
              weekday_hour_value_reg[10:8] <= (weekday_hour_value_reg[10:8] == 3'h6)
                ? 3'h0 : weekday_hour_value_reg[10:8] + 3'h1;
            end
          end
        end
      end
    end
  end

  always_comb begin
    case (ptr)
      ccac_pkg::PTR_MINUTE_SECOND_VALUE: win_rd = al_minute_second_value_reg;
      ccac_pkg::PTR_WDHR: win_rd = al_wdhr_reg;
      ccac_pkg::PTR_MTHDY: win_rd = al_mthdy_reg;
      default: win_rd = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      al_minute_second_value_reg <= 16'h0000;
      al_wdhr_reg <= 16'h0000;
      al_mthdy_reg <= 16'h0000;
    end else if (i_ce && wr && req.adr == ccac_pkg::ADDR_ALWIN_HI) begin
      case (ptr)
        ccac_pkg::PTR_MINUTE_SECOND_VALUE: al_minute_second_value_reg <= (al_minute_second_value_reg & ~wmask)
          | (req.dat & wmask & ccac_pkg::MINUTE_SECOND_VALUE_MASK);
        ccac_pkg::PTR_WDHR: if (unlocked) begin
          al_wdhr_reg <= (al_wdhr_reg & ~wmask)
            | (req.dat & wmask & ccac_pkg::WEEKDAY_HOUR_VALUE_MASK);
        end
        ccac_pkg::PTR_MTHDY: if (unlocked) begin
          al_mthdy_reg <= (al_mthdy_reg & ~wmask)
            | (req.dat & wmask & ccac_pkg::MTHDY_MASK);
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    case (alcfg_reg[13:10])
      ccac_pkg::AM_HALF: match = 1'b1;
      ccac_pkg::AM_SEC: match = half_reg;
      ccac_pkg::AM_10S: match = minute_second_value_reg[3:0] == al_minute_second_value_reg[3:0];
      ccac_pkg::AM_MIN: match = minute_second_value_reg[6:0] == al_minute_second_value_reg[6:0];
      ccac_pkg::AM_10M: match = minute_second_value_reg[11:0] == al_minute_second_value_reg[11:0];
      ccac_pkg::AM_HOUR: match = minute_second_value_reg == al_minute_second_value_reg;
      ccac_pkg::AM_DAY: match = minute_second_value_reg == al_minute_second_value_reg
        && weekday_hour_value_reg[5:0] == al_wdhr_reg[5:0];
      ccac_pkg::AM_WEEK: match = minute_second_value_reg == al_minute_second_value_reg
        && weekday_hour_value_reg == al_wdhr_reg;
      ccac_pkg::AM_MONTH: match = minute_second_value_reg == al_minute_second_value_reg
        && weekday_hour_value_reg[5:0] == al_wdhr_reg[5:0]
        && mthdy_reg[5:0] == al_mthdy_reg[5:0];
      ccac_pkg::AM_YEAR: match = minute_second_value_reg == al_minute_second_value_reg
        && weekday_hour_value_reg[5:0] == al_wdhr_reg[5:0]
        && mthdy_reg == al_mthdy_reg;
      default: match = 1'b0;
    endcase
  end
  // Coarser masks fire once, at the end of the matching second,
  // while the time value still holds the matched digits
  assign alarm_hit = alcfg_reg[ccac_pkg::ALC_EN_BIT]
    && cfg_reg[ccac_pkg::CFG_EN_BIT] && half_tick && match
    && (alcfg_reg[13:10] == ccac_pkg::AM_HALF || half_reg);

  // Alarm config; hardware update wins over a same-cycle write
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      alcfg_reg <= 16'h0000;
    end else if (i_ce) begin
      if (alarm_hit) begin
        if (alcfg_reg[7:0] != 8'h00) begin
          alcfg_reg[7:0] <= alcfg_reg[7:0] - 8'h01;
        end else if (alcfg_reg[ccac_pkg::ALC_ENDLESS_REPEAT_BIT]) begin
          alcfg_reg[7:0] <= ccac_pkg::RPT_MAX;
        end else begin
          alcfg_reg[ccac_pkg::ALC_EN_BIT] <= 1'b0;
        end
      end else if (wr && req.adr == ccac_pkg::ADDR_ALCFG) begin
        if (req.sel[0]) begin
          alcfg_reg[7:0] <= req.dat[7:0];
        end
        if (req.sel[1]) begin
          alcfg_reg[15:8] <= req.dat[15:8];
        end
      end else if (win_hi_access && ptr != 2'h0) begin
        alcfg_reg[9:8] <= ptr - 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_alarm_irq <= 1'b0;
      o_alarm_pulse <= 1'b0;
    end else if (i_ce) begin
      o_alarm_irq <= alarm_hit;
      if (alarm_hit) begin
        o_alarm_pulse <= ~o_alarm_pulse;
      end
    end
  end

  always_comb begin
    case (req.adr)
      ccac_pkg::ADDR_CFGCAL: rd_next = {cfg_reg[15], 1'b0, cfg_reg[13],
        sec_cnt_reg[0], half_reg, 3'h0, cfg_reg[7:0]};
      ccac_pkg::ADDR_ALCFG: rd_next = alcfg_reg;
      ccac_pkg::ADDR_WEEKDAY_HOUR_VALUE: rd_next = weekday_hour_value_reg;
      ccac_pkg::ADDR_MINUTE_SECOND_VALUE: rd_next = minute_second_value_reg;
      ccac_pkg::ADDR_ALWIN_LO: rd_next = {8'h00, win_rd[7:0]};
      ccac_pkg::ADDR_ALWIN_HI: rd_next = win_rd;
      ccac_pkg::ADDR_MTHDY: rd_next = mthdy_reg;
      default: rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_wb_dat <= 16'h0000;
    end else if (i_ce && rd) begin
      o_wb_dat <= rd_next;
    end
  end
endmodule : ccac_top

// File: ccac_top_tb_top.sv
module ccac_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [1:0] sel = 2'h0;
  logic [15:0] wdat = 16'h0000, rdat, q;
  logic ack, irq, pulse;
  int mismatches = 0, checks = 0, cyc_n = 0, irq_n = 0;

  always #5 clk = ~clk;

  // Short time base so a second is 64 cycles
  ccac_top #(.TB_DIV(2), .HALF_TICKS(16)) DUT (.i_clk(clk), .i_reset(rst),
    .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_alarm_irq(irq), .o_alarm_pulse(pulse));

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (irq === 1'b1) begin
      irq_n <= irq_n + 1;
    end
  end

  always @(posedge clk) begin
    if (cyc_n == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Request held until the edge that samples ack high; only the
  // bench timeout ends a wait that never gets an answer
  task automatic wb(input logic w, input logic [3:0] a, input logic [1:0] s,
                    input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    check(16'(n), 16'h0002);
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wb(1'b1, a, 2'h3, d);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    wb(1'b0, a, 2'h3, 16'h0000);
  endtask : rd

  task automatic t_regs();
    rd(ccac_pkg::ADDR_MTHDY);
    check(q, 16'h0101);
    rd(4'hf);
    check(q, 16'h0000);
    wr(ccac_pkg::ADDR_WEEKDAY_HOUR_VALUE, 16'h0523);
    rd(ccac_pkg::ADDR_WEEKDAY_HOUR_VALUE);
    check(q, 16'h0000);
    wr(ccac_pkg::ADDR_CFGCAL, 16'h2000);
    wr(ccac_pkg::ADDR_WEEKDAY_HOUR_VALUE, 16'hfde3);
    rd(ccac_pkg::ADDR_WEEKDAY_HOUR_VALUE);
    check(q, 16'h0523);
    wr(ccac_pkg::ADDR_MINUTE_SECOND_VALUE, 16'hd9d9);
    rd(ccac_pkg::ADDR_MINUTE_SECOND_VALUE);
    check(q, 16'h5959);
    wr(ccac_pkg::ADDR_ALCFG, 16'h0200);
    wr(ccac_pkg::ADDR_ALWIN_HI, 16'hf231);
    wr(ccac_pkg::ADDR_ALWIN_HI, 16'hfde3);
    wr(ccac_pkg::ADDR_ALWIN_HI, 16'hd9d9);
    rd(ccac_pkg::ADDR_ALCFG);
    check(q & 16'h0300, 16'h0000);
    wr(ccac_pkg::ADDR_ALCFG, 16'h0200);
    rd(ccac_pkg::ADDR_ALWIN_HI);
    check(q, 16'h1231);
    rd(ccac_pkg::ADDR_ALWIN_HI);
    check(q, 16'h0523);
    rd(ccac_pkg::ADDR_ALWIN_HI);
    check(q, 16'h5959);
  endtask : t_regs

  task automatic t_roll();
    int n;
    n = 0;
    wr(ccac_pkg::ADDR_WEEKDAY_HOUR_VALUE, 16'h0623);
    wr(ccac_pkg::ADDR_MINUTE_SECOND_VALUE, 16'h5959);
    wr(ccac_pkg::ADDR_CFGCAL, 16'ha000);
    do begin
      rd(ccac_pkg::ADDR_MINUTE_SECOND_VALUE);
      n++;
    end while (q === 16'h5959 && n < 100);
    check(q, 16'h0000);
    do begin
      rd(ccac_pkg::ADDR_CFGCAL);
      n++;
    end while (q[ccac_pkg::CFG_HALF_BIT] !== 1'b1 && n < 200);
    wr(ccac_pkg::ADDR_CFGCAL, 16'h2000);
    rd(ccac_pkg::ADDR_WEEKDAY_HOUR_VALUE);
    check(q, 16'h0000);
    wb(1'b1, ccac_pkg::ADDR_MINUTE_SECOND_VALUE, 2'h1, 16'h0000);
    rd(ccac_pkg::ADDR_CFGCAL);
    check(16'(q[ccac_pkg::CFG_HALF_BIT]), 16'h0000);
  endtask : t_roll

  task automatic t_trim();
    int t0;
    // calibration written while the timer is stopped
    wr(ccac_pkg::ADDR_CFGCAL, 16'h20ff);
    wr(ccac_pkg::ADDR_MINUTE_SECOND_VALUE, 16'h0059);
    wr(ccac_pkg::ADDR_CFGCAL, 16'ha0ff);
    do begin
      rd(ccac_pkg::ADDR_MINUTE_SECOND_VALUE);
    end while (q === 16'h0059);
    t0 = cyc_n;
    check(q, 16'h0100);
    do begin
      rd(ccac_pkg::ADDR_MINUTE_SECOND_VALUE);
    end while (q === 16'h0100);
    t0 = cyc_n - t0;
    wr(ccac_pkg::ADDR_CFGCAL, 16'h2000);
    // Four extra base ticks stretch that second from 64 to 72 cycles
    check(16'(t0 > 68 && t0 < 76), 16'h0001);
  endtask : t_trim

  task automatic t_alarm(input logic [3:0] mask, input logic [7:0] rpt,
                         input logic endless_repeat, input int exp_n, input logic en);
    int base;
    // alarm armed while time is stopped
    // repeat written while no rollover is near
    wr(ccac_pkg::ADDR_ALCFG, {1'b1, endless_repeat, mask, 2'b00, rpt});
    base = irq_n;
    wr(ccac_pkg::ADDR_CFGCAL, 16'ha000);
    repeat (400) @(posedge clk);
    wr(ccac_pkg::ADDR_CFGCAL, 16'h2000);
    rd(ccac_pkg::ADDR_ALCFG);
    base = irq_n - base;
    check(16'(base > 3 ? 4 : base), 16'(exp_n));
    check(16'(q[ccac_pkg::ALC_EN_BIT]), 16'(en));
    check(16'(pulse), 16'(irq_n[0]));
  endtask : t_alarm

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_roll();
    t_trim();
    t_alarm(ccac_pkg::AM_HALF, 8'h00, 1'b0, 1, 1'b0);
    t_alarm(ccac_pkg::AM_HALF, 8'h02, 1'b0, 3, 1'b0);
    t_alarm(ccac_pkg::AM_SEC, 8'h01, 1'b0, 2, 1'b0);
    // time set while the alarm is off
    wr(ccac_pkg::ADDR_MINUTE_SECOND_VALUE, 16'h0008);
    t_alarm(ccac_pkg::AM_10S, 8'h01, 1'b0, 1, 1'b1);
    t_alarm(ccac_pkg::AM_HALF, 8'h01, 1'b1, 4, 1'b1);
    t_alarm(ccac_pkg::AM_HALF, 8'hff, 1'b0, 4, 1'b1);
    report_and_stop();
  end
endmodule : ccac_top_tb_top

bind ccac_top ccac_sva #(.TB_DIV(TB_DIV), .HALF_TICKS(HALF_TICKS)) u_sva (
  .i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_alarm_irq(o_alarm_irq),
  .o_alarm_pulse(o_alarm_pulse));
